// *** verilog/trig_record_buffer.sv ***
// Triggered record capture with streaming FIFO or external bulk buffer.
// Assumes converter samples and trigger pin are asynchronous to clk_sys;
// the external memory and host command inputs run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "trb_defs.svh"

module trig_record_buffer (
  input  wire logic                  clk_sys,       // System clock
  input  wire logic                  sys_rst,       // Sync reset, high
  input  wire logic [`SAMPLE_W-1:0]  adc_sample,    // Converter word, pin
  input  wire logic                  ext_trig,      // Trigger pin
  input  wire trb_pkg::mode_t        mode,          // Operating mode
  input  wire trb_pkg::trig_src_t    trig_src,      // Trigger source
  input  wire logic [`SAMPLE_W-1:0]  trig_level,    // Level threshold
  input  wire logic [`LEN_W-1:0]     rec_len,       // Samples per record
  input  wire logic [`LEN_W-1:0]     rec_count,     // Records per set
  input  wire logic                  big_family,    // 1 GBytes buffer
  input  wire logic                  proc_en,       // Energy processing
  input  wire logic [`DECIM_W-1:0]   decim_log2,    // Log2 reduction
  input  wire logic                  arm,           // Pulse: arm set
  input  wire logic                  readout_start, // Pulse: read set
  input  wire logic                  ovf_clear,     // Pulse: clear flag
  input  wire logic                  link_ready,    // Link accepts word
  input  wire logic [`SAMPLE_W-1:0]  dram_rd_data,  // Memory read word
  input  wire logic                  dram_rd_valid, // Memory read done
  output logic [`SAMPLE_W-1:0]       link_data,     // Word to host link
  output logic                       link_valid,    // Word is valid
  output logic                       dram_we,       // Memory write
  output logic [`DRAM_AW-1:0]        dram_wr_addr,  // Memory write addr
  output logic [`SAMPLE_W-1:0]       dram_wr_data,  // Memory write word
  output logic                       dram_re,       // Memory read
  output logic [`DRAM_AW-1:0]        dram_rd_addr,  // Memory read addr
  output logic                       acq_done,      // Set acquired
  output logic                       overflow,      // Sticky overflow
  output logic [`LEN_W-1:0]          records_stored // Records in set
);
  fifo_if bus ();

  record_fifo u_fifo (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .port    (bus.store)
  );

  logic [`SAMPLE_W-1:0]  adc_s1;
  logic [`SAMPLE_W-1:0]  adc_s2;
  logic [`SAMPLE_W-1:0]  adc_s3;
  logic                  trig_s1;
  logic                  trig_s2;
  logic                  trig_s3;
  logic                  trigger;
  logic [31:0]           energy_sq;
  logic [`SAMPLE_W-1:0]  rec_sample;
  logic                  stream_mode;
  logic                  cont_mode;
  logic [`LEN_W-1:0]     eff_len;
  logic [`DRAM_CW-1:0]   dram_cap;
  logic [`DRAM_CW-1:0]   dram_wa;
  logic                  room;
  logic                  start_req;
  logic                  start;
  trb_pkg::cap_state_t   cap_state;
  logic [`LEN_W-1:0]     cap_cnt;
  logic                  cap_multi;
  logic                  armed;
  logic [11:0]           rec_seq;
  logic [`DCNT_W-1:0]    dcnt;
  logic                  dlast;
  logic [`ACC_W-1:0]     acc;
  logic [`ACC_W-1:0]     next_acc;
  logic [`ACC_W-1:0]     avg;
  trb_pkg::rd_state_t    rd_state;
  logic [`DRAM_CW-1:0]   rd_ptr;

  // Three-stage capture of the asynchronous pins
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      adc_s1  <= '0;
      adc_s2  <= '0;
      adc_s3  <= '0;
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end
    else
    begin
      adc_s1  <= adc_sample;
      adc_s2  <= adc_s1;
      adc_s3  <= adc_s2;
      trig_s1 <= ext_trig;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end

  // Rising edge of the pin or an upward level crossing
  assign trigger = (trig_src == trb_pkg::TRIG_LEVEL)
                 ? ($signed(adc_s2) >= $signed(trig_level) &&
                    $signed(adc_s3) <  $signed(trig_level))
                 : (trig_s2 && !trig_s3);

  assign energy_sq  = $signed(adc_s2) * $signed(adc_s2);
  assign rec_sample = proc_en ? energy_sq[30:15] : adc_s2;

  assign stream_mode = (mode == trb_pkg::MODE_TRIG_STREAM);
  assign cont_mode   = (mode == trb_pkg::MODE_CONT_SKIP) ||
                       (mode == trb_pkg::MODE_CONT_DECIM);
  assign dram_cap    = big_family ? `DRAM_WORDS_BIG
                                  : `DRAM_WORDS_SML;

  always_comb
  begin
    eff_len = (rec_len == '0) ? 16'h0001 : rec_len;
    if (stream_mode && eff_len > `REC_MAX_STREAM)
    begin
      eff_len = `REC_MAX_STREAM;
    end
  end

  // Stream room for header plus record, one word spare for the write in flight; bulk room for the record alone
  assign room = stream_mode
              ? ({1'b0, bus.free} > eff_len + 16'h0001)
              : (dram_wa + {14'h0000, eff_len} <= dram_cap);

  assign start_req = (cap_state == trb_pkg::CAP_IDLE) && trigger &&
                     (stream_mode || (mode == trb_pkg::MODE_MULTI_RECORD
                                      && armed));
  assign start     = start_req && room;

  // Record capture; busy state masks new triggers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cap_state <= trb_pkg::CAP_IDLE;
      cap_cnt   <= '0;
      cap_multi <= 1'b0;
    end
    else
    begin
      case (cap_state)
        trb_pkg::CAP_IDLE:
        begin
          if (start)
          begin
            cap_state <= trb_pkg::CAP_DATA;
            cap_cnt   <= eff_len;
            cap_multi <= !stream_mode;
          end
        end
        trb_pkg::CAP_DATA:
        begin
          cap_cnt <= cap_cnt - 1'b1;
          if (cap_cnt == 16'h0001)
          begin
            cap_state <= trb_pkg::CAP_IDLE;
          end
        end
        default:
        begin
          cap_state <= trb_pkg::CAP_IDLE;
        end
      endcase
    end
  end

  // Sample skip and power-of-two averaging for continuous input
  assign dlast    = (dcnt == ((4'h1 << decim_log2) - 4'h1));
  assign next_acc = ((dcnt == '0) ? '0 : acc) +
                    {{4{rec_sample[`SAMPLE_W-1]}}, rec_sample};
  assign avg      = $signed(next_acc) >>> decim_log2;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || !cont_mode)
    begin
      dcnt <= '0;
      acc  <= '0;
    end
    else
    begin
      dcnt <= dlast ? '0 : dcnt + 1'b1;
      acc  <= next_acc;
    end
  end

  // Internal FIFO writes: header, record words or reduced stream
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      bus.wr_valid <= 1'b0;
      bus.wr_data  <= '0;
      rec_seq      <= '0;
    end
    else
    begin
      bus.wr_valid <= 1'b0;
      if (start && stream_mode)
      begin
        bus.wr_valid <= 1'b1;
        bus.wr_data  <= {`HDR_TAG, rec_seq};
        rec_seq      <= rec_seq + 1'b1;
      end
      else if (cap_state == trb_pkg::CAP_DATA && !cap_multi)
      begin
        bus.wr_valid <= 1'b1;
        bus.wr_data  <= rec_sample;
      end
      else if (mode == trb_pkg::MODE_CONT_SKIP && dcnt == '0)
      begin
        bus.wr_valid <= 1'b1;
        bus.wr_data  <= rec_sample;
      end
      else if (mode == trb_pkg::MODE_CONT_DECIM && dlast)
      begin
        bus.wr_valid <= 1'b1;
        bus.wr_data  <= avg[`SAMPLE_W-1:0];
      end
    end
  end

  // External buffer writes, set bookkeeping and the done flag
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      dram_we        <= 1'b0;
      dram_wr_addr   <= '0;
      dram_wr_data   <= '0;
      dram_wa        <= '0;
      armed          <= 1'b0;
      acq_done       <= 1'b0;
      records_stored <= '0;
    end
    else
    begin
      dram_we <= 1'b0;
      if (arm)
      begin
        armed          <= 1'b1;
        acq_done       <= 1'b0;
        records_stored <= '0;
        dram_wa        <= '0;
      end
      else if (cap_state == trb_pkg::CAP_DATA && cap_multi)
      begin
        dram_we      <= 1'b1;
        dram_wr_addr <= dram_wa[`DRAM_AW-1:0];
        dram_wr_data <= rec_sample;
        dram_wa      <= dram_wa + 1'b1;
        if (cap_cnt == 16'h0001)
        begin
          records_stored <= records_stored + 1'b1;
          if (records_stored + 1'b1 >= rec_count)
          begin
            acq_done <= 1'b1;
            armed    <= 1'b0;
          end
        end
      end
    end
  end

  // Sticky overflow; a new loss wins over the clear
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      overflow <= 1'b0;
    end
    else if ((start_req && !room) ||
             (bus.wr_valid && !bus.wr_ready))
    begin
      overflow <= 1'b1;
    end
    else if (ovf_clear)
    begin
      overflow <= 1'b0;
    end
  end

  // Readout of a completed set, one word in flight at a time
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rd_state     <= trb_pkg::RD_IDLE;
      rd_ptr       <= '0;
      dram_re      <= 1'b0;
      dram_rd_addr <= '0;
    end
    else
    begin
      dram_re <= 1'b0;
      case (rd_state)
        trb_pkg::RD_IDLE:
        begin
          if (readout_start && acq_done && !arm)
          begin
            rd_state <= trb_pkg::RD_REQ;
            rd_ptr   <= '0;
          end
        end
        trb_pkg::RD_REQ:
        begin
          // Stop at the end of the set, or when the set is re-armed
          if (rd_ptr == dram_wa || !acq_done || arm)
          begin
            rd_state <= trb_pkg::RD_IDLE;
          end
          else if (!link_valid)
          begin
            dram_re      <= 1'b1;
            dram_rd_addr <= rd_ptr[`DRAM_AW-1:0];
            rd_ptr       <= rd_ptr + 1'b1;
            rd_state     <= trb_pkg::RD_WAIT;
          end
        end
        trb_pkg::RD_WAIT:
        begin
          if (dram_rd_valid)
          begin
            rd_state <= trb_pkg::RD_REQ;
          end
        end
        default:
        begin
          rd_state <= trb_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // Link output register fed by the FIFO or by external readout
  assign bus.rd_ready = (mode != trb_pkg::MODE_MULTI_RECORD) &&
                        (!link_valid || link_ready);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      link_valid <= 1'b0;
      link_data  <= '0;
    end
    else
    begin
      if (link_valid && link_ready)
      begin
        link_valid <= 1'b0;
      end
      if (bus.rd_valid && bus.rd_ready)
      begin
        link_valid <= 1'b1;
        link_data  <= bus.rd_data;
      end
      else if (rd_state == trb_pkg::RD_WAIT && dram_rd_valid)
      begin
        link_valid <= 1'b1;
        link_data  <= dram_rd_data;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_stream_start;
    start && stream_mode;
  endsequence

  sequence s_header_written;
    bus.wr_valid && bus.wr_data[15:12] == `HDR_TAG;
  endsequence

  a_header_first: assert property (s_stream_start |=>
    s_header_written ##0 (cap_state == trb_pkg::CAP_DATA) ##1 bus.wr_valid)
    else $error("record header not written before samples");
  a_retrig_ignored: assert property (
    cap_state == trb_pkg::CAP_DATA && cap_cnt > 16'h0001 |=>
    cap_state == trb_pkg::CAP_DATA &&
    cap_cnt == $past(cap_cnt) - 16'h0001)
    else $error("record window disturbed by trigger");
  a_drop_outside: assert property (
    cap_state == trb_pkg::CAP_IDLE |=> !dram_we)
    else $error("bulk write outside a record window");
  a_done_count: assert property ($rose(acq_done) |->
    records_stored >= rec_count && !armed)
    else $error("done flag set before all records stored");
  a_ovf_sticky: assert property (
    overflow && !ovf_clear |=> overflow)
    else $error("overflow flag dropped without clear");
  a_ovf_on_loss: assert property (start_req && !room |=> overflow)
    else $error("record without room not flagged");
  a_stream_len: assert property (
    cap_state == trb_pkg::CAP_DATA && !cap_multi |->
    cap_cnt <= `REC_MAX_STREAM)
    else $error("streaming record longer than FIFO");
  a_read_after: assert property (dram_re |-> acq_done)
    else $error("bulk readout before set complete");
  a_link_hold: assert property (
    link_valid && !link_ready |=> link_valid && $stable(link_data))
    else $error("link word changed while stalled");
endmodule : trig_record_buffer

`default_nettype wire

// *** verilog/trb_defs.svh ***
// Constants for the triggered record buffer: widths, buffer sizes, tags.
// Assumes a single 40 MHz clock domain and 16-bit converter samples.
`ifndef TRB_DEFS_SVH
`define TRB_DEFS_SVH

`define SAMPLE_W        16
`define LEN_W           16
// Internal streaming buffer: 32 kBytes of 16-bit words
`define BRAM_BYTES      32768
`define BRAM_AW         14
`define BRAM_DEPTH      15'h4000
// Longest streaming record still fits with its header and a spare word
`define REC_MAX_STREAM  16'h3FFE
// External buffer, in 16-bit words: 1 GBytes or 256 MByte
`define DRAM_AW         29
`define DRAM_CW         30
`define DRAM_WORDS_BIG  30'h2000_0000
`define DRAM_WORDS_SML  30'h0800_0000
// Record header word layout
`define HDR_TAG         4'hA
`define HDR_TAG_POS     12
`define DECIM_W         2
`define DCNT_W          4
`define ACC_W           20

`endif

// *** verilog/trb_pkg.sv ***
// Types shared by the record buffer modules.
// Assumes trb_defs.svh is included before use of the widths.
package trb_pkg;

  typedef enum logic [1:0] {
    MODE_MULTI_RECORD,
    MODE_TRIG_STREAM,
    MODE_CONT_SKIP,
    MODE_CONT_DECIM
  } mode_t;

  typedef enum logic {
    TRIG_EXTERNAL,
    TRIG_LEVEL
  } trig_src_t;

  typedef enum {
    CAP_IDLE,
    CAP_DATA
  } cap_state_t;

  typedef enum {
    RD_IDLE,
    RD_REQ,
    RD_WAIT
  } rd_state_t;

endpackage : trb_pkg

// *** verilog/fifo_if.sv ***
// Write and read sides of the internal record FIFO.
// Assumes one clock shared by both sides.
`timescale 1ns/1ps
`default_nettype none
`include "trb_defs.svh"

interface fifo_if;
  logic                  wr_valid;
  logic [`SAMPLE_W-1:0]  wr_data;
  logic                  wr_ready;
  logic                  rd_valid;
  logic [`SAMPLE_W-1:0]  rd_data;
  logic                  rd_ready;
  logic [`BRAM_AW:0]     free;

  modport user  (output wr_valid, wr_data, rd_ready,
                 input  wr_ready, rd_valid, rd_data, free);
  modport store (input  wr_valid, wr_data, rd_ready,
                 output wr_ready, rd_valid, rd_data, free);
endinterface : fifo_if

`default_nettype wire

// *** verilog/record_fifo.sv ***
// Flip-flop FIFO holding records for the streaming modes.
// Assumes writer and reader share clk_sys; show-ahead read data.
`timescale 1ns/1ps
`default_nettype none
`include "trb_defs.svh"

module record_fifo (
  input  wire logic clk_sys,  // System clock
  input  wire logic sys_rst,  // Synchronous reset, high
  fifo_if.store     port      // Write and read sides
);
  logic [`SAMPLE_W-1:0] mem [2**`BRAM_AW];
  logic [`BRAM_AW-1:0]  wp;
  logic [`BRAM_AW-1:0]  rp;
  logic [`BRAM_AW:0]    count;
  logic                 push;
  logic                 pop;

  assign push          = port.wr_valid && port.wr_ready;
  assign pop           = port.rd_valid && port.rd_ready;
  assign port.wr_ready = (count != `BRAM_DEPTH);
  assign port.rd_valid = (count != '0);
  assign port.rd_data  = mem[rp];
  assign port.free     = `BRAM_DEPTH - count;

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wp] <= port.wr_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wp    <= '0;
      rp    <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wp <= wp + 1'b1;
      end
      if (pop)
      begin
        rp <= rp + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : record_fifo

`default_nettype wire

// *** tb/dram_model.sv ***
// Behavioural external sample memory answering the buffer's requests.
// Assumes requests and answers on clk_sys; slow adds read latency.
`timescale 1ns/1ps
`default_nettype none

module dram_model (
  input  wire logic        clk_sys,      // System clock
  input  wire logic        slow,         // Long read latency
  input  wire logic        dram_we,      // Write strobe
  input  wire logic [28:0] dram_wr_addr, // Write address
  input  wire logic [15:0] dram_wr_data, // Write word
  input  wire logic        dram_re,      // Read strobe
  input  wire logic [28:0] dram_rd_addr, // Read address
  output logic      [15:0] dram_rd_data, // Read word
  output logic             dram_rd_valid // Read answer pulse
);
  logic [15:0] mem [int unsigned];
  int          wait_n = 0;
  logic [28:0] pend;

  initial dram_rd_data = 16'h0000;
  initial dram_rd_valid = 1'b0;

  always @(posedge clk_sys)
  begin
    dram_rd_valid <= 1'b0;
    // Data bus never keeps a stale word
    dram_rd_data <= ~dram_rd_data;
    if (dram_we)
      mem[dram_wr_addr] = dram_wr_data;
    if (dram_re)
    begin
      pend = dram_rd_addr;
      wait_n = slow ? 4 : 1;
    end
    else if (wait_n > 0)
    begin
      wait_n = wait_n - 1;
      if (wait_n == 0)
      begin
        dram_rd_valid <= 1'b1;
        dram_rd_data  <= mem.exists(pend) ? mem[pend] : 16'hFFFF;
      end
    end
  end
endmodule : dram_model

`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the triggered record buffer.
// Assumes dram_model stands in for the external memory.
`timescale 1ns/1ps
`default_nettype none
`include "trb_defs.svh"

module tb;
  logic               clk_sys = 1'b0;
  logic               sys_rst = 1'b1;
  logic [15:0]        adc_sample = 16'h0000;
  logic               ext_trig = 1'b0;
  trb_pkg::mode_t     mode = trb_pkg::MODE_TRIG_STREAM;
  trb_pkg::trig_src_t trig_src = trb_pkg::TRIG_EXTERNAL;
  logic [15:0]        trig_level = 16'h7FFF;
  logic [15:0]        rec_len = 16'h0008;
  logic [15:0]        rec_count = 16'h0003;
  logic               big_family = 1'b1;
  logic               proc_en = 1'b0;
  logic [1:0]         decim_log2 = 2'h0;
  logic               arm = 1'b0, readout_start = 1'b0, ovf_clear = 1'b0;
  logic               link_ready = 1'b1, slow = 1'b1, ramp = 1'b0;
  logic [15:0]        dram_rd_data, link_data, dram_wr_data, records_stored;
  logic [28:0]        dram_wr_addr, dram_rd_addr;
  logic               dram_rd_valid, link_valid, dram_we, dram_re;
  logic               acq_done, overflow;
  logic [15:0]        q[$];
  int                 err_total = 0, n_tests = 0, we_cnt = 0, cyc = 0;
  int                 seq = 0;

  trig_record_buffer i_trig_record_buffer (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .adc_sample(adc_sample),
    .ext_trig(ext_trig), .mode(mode), .trig_src(trig_src),
    .trig_level(trig_level), .rec_len(rec_len), .rec_count(rec_count),
    .big_family(big_family), .proc_en(proc_en), .decim_log2(decim_log2),
    .arm(arm), .readout_start(readout_start), .ovf_clear(ovf_clear),
    .link_ready(link_ready), .dram_rd_data(dram_rd_data),
    .dram_rd_valid(dram_rd_valid), .link_data(link_data),
    .link_valid(link_valid), .dram_we(dram_we),
    .dram_wr_addr(dram_wr_addr), .dram_wr_data(dram_wr_data),
    .dram_re(dram_re), .dram_rd_addr(dram_rd_addr), .acq_done(acq_done),
    .overflow(overflow), .records_stored(records_stored));

  dram_model i_dram_model (
    .clk_sys(clk_sys), .slow(slow), .dram_we(dram_we),
    .dram_wr_addr(dram_wr_addr), .dram_wr_data(dram_wr_data),
    .dram_re(dram_re), .dram_rd_addr(dram_rd_addr),
    .dram_rd_data(dram_rd_data), .dram_rd_valid(dram_rd_valid));

  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(negedge clk_sys)
    if (ramp)
      adc_sample <= adc_sample + 16'h0001;

  always @(posedge clk_sys)
  begin
    cyc++;
    if (link_valid === 1'b1 && link_ready)
      q.push_back(link_data);
    if (dram_we === 1'b1)
      we_cnt++;
    if (cyc == 40000)
    begin
      err_total++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic step(int n);
    repeat (n) @(negedge clk_sys);
  endtask : step

  task automatic pulse(ref logic s, input int n);
    s = 1'b1;
    step(n);
    s = 1'b0;
    step(3);
  endtask : pulse

  task automatic chk_rec(int b);
    chk("header", q[b], {`HDR_TAG, seq[11:0]});
    seq++;
    for (int i = b + 2; i <= b + rec_len; i++)
      chk("sample step", q[i] - q[i-1], 16'h0001);
  endtask : chk_rec

  task automatic t_stream;
    ramp = 1'b1;
    pulse(ext_trig, 3);
    pulse(ext_trig, 3);
    step(60);
    chk("stream words", q.size(), 16'h0009);
    chk_rec(0);
    q.delete();
    $display("test stream done");
  endtask : t_stream

  task automatic t_burst;
    link_ready = 1'b0;
    pulse(ext_trig, 3);
    step(20);
    pulse(ext_trig, 3);
    step(20);
    chk("held burst", q.size(), 16'h0000);
    chk("word offered", link_valid, 16'h0001);
    link_ready = 1'b1;
    step(40);
    chk("burst words", q.size(), 16'h0012);
    chk_rec(0);
    chk_rec(9);
    q.delete();
    $display("test burst done");
  endtask : t_burst

  task automatic t_level;
    ramp = 1'b0;
    step(1);
    adc_sample = 16'h0000;
    trig_level = 16'h0040;
    trig_src = trb_pkg::TRIG_LEVEL;
    step(10);
    ramp = 1'b1;
    step(120);
    chk("level words", q.size(), 16'h0009);
    chk("past level", q[1] > 16'h0040, 16'h0001);
    chk_rec(0);
    trig_src = trb_pkg::TRIG_EXTERNAL;
    q.delete();
    $display("test level done");
  endtask : t_level

  task automatic t_proc;
    ramp = 1'b0;
    step(1);
    adc_sample = 16'h4000;
    proc_en = 1'b1;
    step(4);
    pulse(ext_trig, 3);
    step(30);
    chk("proc words", q.size(), 16'h0009);
    chk("header", q[0], {`HDR_TAG, seq[11:0]});
    seq++;
    for (int i = 1; i < 9; i++)
      chk("energy", q[i], 16'h2000);
    proc_en = 1'b0;
    q.delete();
    $display("test processing done");
  endtask : t_proc

  task automatic t_ovf;
    rec_len = 16'h1000;
    link_ready = 1'b0;
    ramp = 1'b1;
    for (int r = 0; r < 4; r++)
    begin
      if (r == 3)
        chk("room left", overflow, 16'h0000);
      pulse(ext_trig, 3);
      step(4110);
    end
    chk("overflow", overflow, 16'h0001);
    step(10);
    chk("sticky", overflow, 16'h0001);
    pulse(ovf_clear, 1);
    chk("cleared", overflow, 16'h0000);
    link_ready = 1'b1;
    step(12400);
    chk("kept words", q.size(), 16'h3003);
    chk("first kept", q[0][15:12], `HDR_TAG);
    rec_len = 16'h0004;
    q.delete();
    $display("test overflow done");
  endtask : t_ovf

  task automatic t_multi;
    mode = trb_pkg::MODE_MULTI_RECORD;
    step(2);
    we_cnt = 0;
    pulse(ext_trig, 3);
    step(20);
    chk("unarmed", we_cnt, 16'h0000);
    pulse(arm, 1);
    for (int r = 0; r < 3; r++)
    begin
      pulse(ext_trig, 3);
      step(15);
      chk("stored", records_stored, r + 1);
      chk("done", acq_done, r == 2);
    end
    chk("writes", we_cnt, 16'h000C);
    chk("no early read", q.size(), 16'h0000);
    pulse(ext_trig, 3);
    step(15);
    chk("after done", we_cnt, 16'h000C);
    pulse(readout_start, 1);
    step(300);
    chk("read words", q.size(), 16'h000C);
    for (int i = 1; i < 12; i++)
      if (i % 4 != 0)
        chk("read step", q[i] - q[i-1], 16'h0001);
    q.delete();
    $display("test multi record done");
  endtask : t_multi

  task automatic t_cont;
    trb_pkg::mode_t m [2];
    m[0] = trb_pkg::MODE_CONT_SKIP;
    m[1] = trb_pkg::MODE_CONT_DECIM;
    ramp = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      mode = m[k];
      decim_log2 = (k == 1) ? 2'h1 : 2'h2;
      step(40);
      q.delete();
      step(40);
      chk("reduced step", q[2] - q[1], (k == 1) ? 16'h2 : 16'h4);
      chk("reduced rate", q.size() <= 20, 16'h0001);
    end
    $display("test continuous done");
  endtask : t_cont

  initial
  begin
    step(10);
    sys_rst = 1'b0;
    step(4);
    chk("idle link", link_valid, 16'h0000);
    t_stream();
    t_burst();
    t_level();
    t_proc();
    t_ovf();
    t_multi();
    t_cont();
    close_out();
  end
endmodule : tb

`default_nettype wire
